// ==== hdl/scc_pkg.sv ====
// Package for the string compare/collate datapath: widths, codes, layouts
// Functional notes
// - Formation word loads shifted slice or residue
// - Residue captures shifted bits 0-47, 108-113
// - Move copies buffer word to holding register and output
// - Compare holds buffer until other word formed
// - Per-character equal, forced by force bits
// - All ten equal gives word equal
// - First unequal character encoded to position
// - Collate equal: position plus one, force decode
// - Mismatched characters copied to temp registers
// - Bitwise scan decides formation side greater
// - Greater flag kept for result register
// - Word-position tests blocked on first collate
// - Three equality flops pick fetch sequence
// - Fetch address is base plus bits 3-5
// - Temp character bits 0-2 pick collate char from table word
// - Second fetch overwrites table, fills formation temp
// - Equal collate characters assert collate equal
// - Word position keeps last fetched index
// - Both held in table: no fetch
// - Different words, none held: two fetches
// - One word covers both: one fetch
// - Two four-bit offsets for source, destination
package scc_pkg;
    localparam int CHAR_W = 6;
    localparam int NCHAR = 10;
    localparam int WORD_W = 60;
    localparam int DBL_W = 120;
    localparam int RES_W = 54;
    localparam int POS_W = 4;
    localparam int ADDR_W = 18;
    // Shifted register slice feeding the formation word
    localparam int FORM_LO = 48;
    localparam int RES_LO_W = 48;
    localparam int RES_HI_LO = 108;
    localparam int RES_HI_W = 6;
    localparam int WP_W = 3;
    localparam logic [POS_W-1:0] POS_RESET = 4'h0;
    localparam logic [WP_W-1:0] WP_RESET = 3'h0;

    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_TEST = 7'h02,
        ST_REQ_S = 7'h04,
        ST_WAIT_S = 7'h08,
        ST_REQ_Q = 7'h10,
        ST_WAIT_Q = 7'h20,
        ST_CMP = 7'h40
    } scc_state_type;

    // Memory read request toward central memory
    typedef struct packed {
        logic req;
        logic [ADDR_W-1:0] addr;
    } scc_mem_req_type;

    // Compare outcome toward sequence control
    typedef struct packed {
        logic word_equal;
        logic mismatch;
        logic [POS_W-1:0] pos;
        logic greater;
        logic collate_equal;
        logic collate_unequal;
    } scc_result_type;
endpackage : scc_pkg

// ==== hdl/scc_datapath.sv ====
// String compare/collate datapath: word formation, compare, collate fetch
//
// Added by the designer: the strobed register port and the placing of the registers.
`timescale 1ns/100ps
module scc_datapath #(
    parameter int NCHAR_P = 10
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic [scc_pkg::DBL_W-1:0] shift_data,
    input wire logic load_residue,
    input wire logic load_form,
    input wire logic form_from_residue,
    input wire logic move_op,
    input wire logic load_buffer,
    input wire logic compare_go,
    input wire logic collate_mode,
    input wire logic new_instr,
    input wire logic [scc_pkg::ADDR_W-1:0] table_base_reg,
    input wire logic mem_valid,
    input wire logic [scc_pkg::WORD_W-1:0] memory_read_data_reg,
    input wire logic offset_load,
    input wire logic [scc_pkg::POS_W-1:0] source_offset_in,
    input wire logic [scc_pkg::POS_W-1:0] dest_offset_in,
    output logic [scc_pkg::WORD_W-1:0] memory_write_holding_reg,
    output logic [scc_pkg::WORD_W-1:0] out_word,
    output logic [scc_pkg::NCHAR-1:0] char_equal_vec,
    output scc_pkg::scc_result_type result,
    output scc_pkg::scc_mem_req_type mem_req,
    output logic collate_busy,
    output logic [scc_pkg::POS_W-1:0] source_offset,
    output logic [scc_pkg::POS_W-1:0] dest_offset
);
    import scc_pkg::*;

    logic [WORD_W-1:0] form_word;
    logic [RES_W-1:0] residue;
    logic [WORD_W-1:0] buffer_word;
    logic [NCHAR-1:0] force_equal_bits;
    logic [NCHAR-1:0] next_char_eq;
    logic [POS_W-1:0] char_position_reg;
    logic [POS_W-1:0] first_uneq;
    logic [CHAR_W-1:0] temp_char_buffer_side;
    logic [CHAR_W-1:0] temp_char_formation_side;
    logic [CHAR_W-1:0] bit_equal_vec;
    logic [WORD_W-1:0] table_word;
    logic [WP_W-1:0] word_pos;
    logic first_collate;
    logic eq_tq_ts;
    logic eq_tq_wp;
    logic eq_ts_wp;
    logic formation_side_greater;
    logic next_greater;
    logic sel_s_eq;
    logic sel_q_eq;
    scc_state_type state;
    logic [CHAR_W-1:0] coll_char;
    logic [WP_W-1:0] coll_idx;

    ////////////////////////////////////////////////////////////////////////
    // Word formation and buffering
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            residue <= '0;
        end else if (load_residue) begin
            residue <= {shift_data[RES_HI_LO +: RES_HI_W],
                        shift_data[RES_LO_W-1:0]};
        end
    end

    // Residue bits 0-47 keep word bits 0-47; bits 108-113 land in word bits 54-59
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            form_word <= '0;
        end else if (load_form) begin
            if (form_from_residue) begin
                form_word <= {residue[RES_W-1 -: RES_HI_W],
                              6'h00, residue[RES_LO_W-1:0]};
            end else begin
                form_word <= shift_data[FORM_LO +: WORD_W];
            end
        end
    end

    // Buffer holds a word until the sequencer asks again; compare waits on it
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            buffer_word <= '0;
            memory_write_holding_reg <= '0;
            out_word <= '0;
        end else begin
            if (load_buffer) begin
                buffer_word <= form_word;
            end
            if (move_op) begin
                memory_write_holding_reg <= buffer_word;
                out_word <= buffer_word;
            end
        end
    end

    // Offsets for first words of source and destination fields
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            source_offset <= POS_RESET;
            dest_offset <= POS_RESET;
        end else if (offset_load) begin
            source_offset <= source_offset_in;
            dest_offset <= dest_offset_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Character compare and priority encode; character 0 is leftmost
    always_comb begin
        first_uneq = POS_RESET;
        for (int i = 0; i < NCHAR; i++) begin
            next_char_eq[i] = force_equal_bits[i] ||
                (buffer_word[WORD_W-1-i*CHAR_W -: CHAR_W] ==
                 form_word[WORD_W-1-i*CHAR_W -: CHAR_W]);
        end
        for (int i = NCHAR - 1; i >= 0; i--) begin
            if (!next_char_eq[i]) begin
                first_uneq = POS_W'(i);
            end
        end
    end

    // Temp compare: scan bits from the bottom, highest difference decides
    always_comb begin
        next_greater = 1'b0;
        bit_equal_vec = ~(temp_char_buffer_side ^ temp_char_formation_side);
        for (int b = 0; b < CHAR_W; b++) begin
            if (!bit_equal_vec[b]) begin
                next_greater = temp_char_formation_side[b];
            end
        end
    end

    // Word tests on the characters entering the temps, ready when TEST decides
    assign sel_s_eq = (word_pos == buffer_word[WORD_W-1-first_uneq*CHAR_W -: WP_W]);
    assign sel_q_eq = (word_pos == form_word[WORD_W-1-first_uneq*CHAR_W -: WP_W]);
    assign coll_idx = (state == ST_WAIT_S) ? temp_char_buffer_side[WP_W-1:0]
                                           : temp_char_formation_side[WP_W-1:0];
    // Pick from the returning word; the table register loads on this same edge
    assign coll_char = memory_read_data_reg[WORD_W-1-coll_idx*CHAR_W -: CHAR_W];

    ////////////////////////////////////////////////////////////////////////
    // Compare results, position and temp capture
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            char_equal_vec <= '0;
            result <= '0;
            char_position_reg <= POS_RESET;
            temp_char_buffer_side <= '0;
            temp_char_formation_side <= '0;
            formation_side_greater <= 1'b0;
        end else begin
            result.collate_equal <= 1'b0;
            result.collate_unequal <= 1'b0;
            if (compare_go) begin
                char_equal_vec <= next_char_eq;
                result.word_equal <= &next_char_eq;
                result.mismatch <= ~&next_char_eq;
                if (!(&next_char_eq)) begin
                    char_position_reg <= first_uneq;
                    temp_char_buffer_side <=
                        buffer_word[WORD_W-1-first_uneq*CHAR_W -: CHAR_W];
                    temp_char_formation_side <=
                        form_word[WORD_W-1-first_uneq*CHAR_W -: CHAR_W];
                end
            end
            if (state == ST_TEST && !collate_mode) begin
                formation_side_greater <= next_greater;
                result.greater <= next_greater;
            end
            if (state == ST_WAIT_S && mem_valid) begin
                temp_char_buffer_side <= coll_char;
            end
            if (state == ST_WAIT_Q && mem_valid) begin
                temp_char_formation_side <= coll_char;
            end
            // Same word: one fetch serves the formation side too
            if (state == ST_WAIT_S && mem_valid && eq_tq_ts) begin
                temp_char_formation_side <= memory_read_data_reg[WORD_W-1-
                    temp_char_formation_side[WP_W-1:0]*CHAR_W -: CHAR_W];
            end
            if (state == ST_TEST && collate_mode && eq_ts_wp && !first_collate) begin
                temp_char_buffer_side <=
                    table_word[WORD_W-1-temp_char_buffer_side[WP_W-1:0]*CHAR_W -: CHAR_W];
            end
            if (state == ST_TEST && collate_mode && eq_tq_wp && !first_collate) begin
                temp_char_formation_side <= table_word[WORD_W-1-
                    temp_char_formation_side[WP_W-1:0]*CHAR_W -: CHAR_W];
            end
            if (state == ST_CMP) begin
                if (temp_char_buffer_side == temp_char_formation_side) begin
                    result.collate_equal <= 1'b1;
                    char_position_reg <= char_position_reg + 4'h1;
                end else begin
                    result.collate_unequal <= 1'b1;
                    result.greater <= next_greater;
                    formation_side_greater <= next_greater;
                end
            end
            result.pos <= char_position_reg;
        end
    end

    // Force bits cover every position up to and including the mismatch
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            force_equal_bits <= '0;
        end else if (new_instr) begin
            force_equal_bits <= '0;
        end else if (state == ST_CMP && temp_char_buffer_side == temp_char_formation_side) begin
            for (int i = 0; i < NCHAR; i++) begin
                force_equal_bits[i] <= (POS_W'(i) < char_position_reg + 4'h1);
            end
        end else if (compare_go && &next_char_eq) begin
            force_equal_bits <= '0; // Next word pair starts unforced
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Collate sequencer; fetch count minimised by the equality flops
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            eq_tq_ts <= 1'b0;
            eq_tq_wp <= 1'b0;
            eq_ts_wp <= 1'b0;
        end else if (compare_go) begin
            // Loaded beside the temps, so TEST needs no extra settling state
            eq_tq_ts <= (buffer_word[WORD_W-1-first_uneq*CHAR_W -: WP_W] ==
                         form_word[WORD_W-1-first_uneq*CHAR_W -: WP_W]);
            eq_tq_wp <= sel_q_eq && !first_collate;
            eq_ts_wp <= sel_s_eq && !first_collate;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            state <= ST_IDLE;
            mem_req <= '0;
            collate_busy <= 1'b0;
        end else begin
            mem_req.req <= 1'b0;
            unique case (state)
                ST_IDLE: begin
                    if (compare_go && !(&next_char_eq)) begin
                        state <= ST_TEST;
                        collate_busy <= collate_mode;
                    end
                end
                ST_TEST: begin
                    if (!collate_mode) begin
                        state <= ST_IDLE;
                    end else if (eq_tq_wp && eq_ts_wp) begin
                        state <= ST_CMP;
                    end else if (eq_ts_wp) begin
                        state <= ST_REQ_Q;
                    end else begin
                        state <= ST_REQ_S;
                    end
                end
                ST_REQ_S: begin
                    mem_req.req <= 1'b1;
                    mem_req.addr <= table_base_reg +
                        ADDR_W'(temp_char_buffer_side[CHAR_W-1 -: WP_W]);
                    state <= ST_WAIT_S;
                end
                ST_WAIT_S: begin
                    if (mem_valid) begin
                        state <= (eq_tq_ts || eq_tq_wp) ? ST_CMP : ST_REQ_Q;
                    end
                end
                ST_REQ_Q: begin
                    mem_req.req <= 1'b1;
                    mem_req.addr <= table_base_reg +
                        ADDR_W'(temp_char_formation_side[CHAR_W-1 -: WP_W]);
                    state <= ST_WAIT_Q;
                end
                ST_WAIT_Q: begin
                    if (mem_valid) begin
                        state <= ST_CMP;
                    end
                end
                ST_CMP: begin
                    state <= ST_IDLE;
                    collate_busy <= 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            table_word <= '0;
            word_pos <= WP_RESET;
            first_collate <= 1'b1;
        end else if (new_instr) begin
            first_collate <= 1'b1; // Table contents invalid for a new instruction
        end else if ((state == ST_WAIT_S || state == ST_WAIT_Q) && mem_valid) begin
            table_word <= memory_read_data_reg;
            word_pos <= (state == ST_WAIT_S) ? temp_char_buffer_side[CHAR_W-1 -: WP_W]
                : temp_char_formation_side[CHAR_W-1 -: WP_W];
            first_collate <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    a_word_eq_all: assert property (@(posedge clk_sys) disable iff (!rstn)
        compare_go |=> (result.word_equal == &char_equal_vec))
        else $error("word equal disagrees with character equals");
    a_pos_first_uneq: assert property (@(posedge clk_sys) disable iff (!rstn)
        compare_go && !(&next_char_eq) |=> char_position_reg == $past(first_uneq))
        else $error("position not first unequal");
    a_no_fetch_held: assert property (@(posedge clk_sys) disable iff (!rstn)
        state == ST_TEST && collate_mode && eq_tq_wp && eq_ts_wp |=> !mem_req.req[*2])
        else $error("fetch issued for held table word");
    a_block_first: assert property (@(posedge clk_sys) disable iff (!rstn)
        compare_go && first_collate |=> !eq_tq_wp && !eq_ts_wp)
        else $error("word tests not blocked on first collate");
    a_fetch_addr: assert property (@(posedge clk_sys) disable iff (!rstn)
        state == ST_REQ_S |=> mem_req.req && mem_req.addr == $past(table_base_reg) +
            ADDR_W'($past(temp_char_buffer_side[CHAR_W-1 -: WP_W])))
        else $error("table fetch address wrong");
    a_wp_tracks: assert property (@(posedge clk_sys) disable iff (!rstn)
        state == ST_WAIT_Q && mem_valid |=> word_pos ==
            $past(temp_char_formation_side[CHAR_W-1 -: WP_W]))
        else $error("word position not last fetched");
    a_coll_eq: assert property (@(posedge clk_sys) disable iff (!rstn)
        state == ST_CMP && temp_char_buffer_side == temp_char_formation_side
            |=> result.collate_equal && !result.collate_unequal)
        else $error("collate equal missing");
    a_buffer_hold: assert property (@(posedge clk_sys) disable iff (!rstn)
        !load_buffer |=> buffer_word == $past(buffer_word))
        else $error("buffer changed without load");
    a_form_slice: assert property (@(posedge clk_sys) disable iff (!rstn)
        load_form && !form_from_residue |=> form_word == $past(shift_data[FORM_LO +: WORD_W]))
        else $error("formation word not loaded from slice");
endmodule : scc_datapath

// ==== bench/scc_mem_model.sv ====
// Central memory model serving collate table reads for the datapath
`timescale 1ns/100ps
module scc_mem_model (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire scc_pkg::scc_mem_req_type mem_req,
    input wire logic [scc_pkg::ADDR_W-1:0] table_base_reg,
    input wire logic slow,
    output logic mem_valid,
    output logic [scc_pkg::WORD_W-1:0] memory_read_data_reg,
    output logic [7:0] fetch_count
);
    import scc_pkg::*;
    logic [2:0] word_idx;
    logic [3:0] wait_cnt;
    logic pending;
    ////////////////////////////////////////////////////////////
    // Collate value ignores bits 3 and 0, so ties cross table words
    function automatic logic [5:0] coll(input logic [5:0] c);
        return c & 6'h36;
    endfunction : coll
    ////////////////////////////////////////////////////////////
    // One read at a time; data line toggles junk outside the valid cycle
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            mem_valid <= 1'b0;
            pending <= 1'b0;
            word_idx <= 3'h0;
            wait_cnt <= 4'h0;
            fetch_count <= 8'h00;
            memory_read_data_reg <= '0;
        end else begin
            mem_valid <= 1'b0;
            memory_read_data_reg <= ~memory_read_data_reg;
            if (mem_req.req && !pending) begin
                pending <= 1'b1;
                word_idx <= 3'(mem_req.addr - table_base_reg);
                wait_cnt <= slow ? 4'h6 : 4'h0;
                fetch_count <= fetch_count + 8'h01;
            end else if (pending && wait_cnt != 4'h0) begin
                wait_cnt <= wait_cnt - 4'h1;
            end else if (pending) begin
                // Eight collate characters, leftmost first
                pending <= 1'b0;
                mem_valid <= 1'b1;
                for (int k = 0; k < 8; k++) begin
                    memory_read_data_reg[59-6*k -: 6] <= coll({word_idx, 3'(k)});
                end
            end
        end
    end
endmodule : scc_mem_model

// ==== bench/tb_top.sv ====
// Self-checking bench for the string compare/collate datapath
`timescale 1ns/100ps
module tb_top;
    import scc_pkg::*;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic [DBL_W-1:0] shift_data = '0;
    logic load_residue = 1'b0, load_form = 1'b0, form_from_residue = 1'b0, move_op = 1'b0;
    logic load_buffer = 1'b0, compare_go = 1'b0, collate_mode = 1'b0, new_instr = 1'b0;
    logic offset_load = 1'b0, slow = 1'b0, mem_valid, collate_busy;
    logic [ADDR_W-1:0] table_base_reg = 18'h00000;
    logic [POS_W-1:0] source_offset_in = 4'h0, dest_offset_in = 4'h0;
    logic [POS_W-1:0] source_offset, dest_offset;
    logic [WORD_W-1:0] memory_read_data_reg, memory_write_holding_reg, out_word;
    logic [NCHAR-1:0] char_equal_vec;
    scc_result_type result;
    scc_mem_req_type mem_req;
    logic [7:0] fetch_count;
    int fail_count = 0, checks = 0, frc = 0, wp = -1;
    logic [31:0] seed = 32'h0000259C;
    logic [5:0] pos_t [6] = '{6'h01, 6'h04, 6'h07, 6'h00, 6'h09, 6'h05};
    logic [5:0] ts_t [6] = '{6'h10, 6'h19, 6'h30, 6'h25, 6'h22, 6'h2A};
    logic [5:0] tq_t [6] = '{6'h18, 6'h18, 6'h21, 6'h24, 6'h2B, 6'h2A};

    always #2 clk_sys = ~clk_sys;

    scc_datapath uut (.clk_sys(clk_sys), .rstn(rstn), .shift_data(shift_data),
        .load_residue(load_residue), .load_form(load_form),
        .form_from_residue(form_from_residue), .move_op(move_op), .load_buffer(load_buffer),
        .compare_go(compare_go), .collate_mode(collate_mode), .new_instr(new_instr),
        .table_base_reg(table_base_reg), .mem_valid(mem_valid),
        .memory_read_data_reg(memory_read_data_reg), .offset_load(offset_load),
        .source_offset_in(source_offset_in), .dest_offset_in(dest_offset_in),
        .memory_write_holding_reg(memory_write_holding_reg), .out_word(out_word),
        .char_equal_vec(char_equal_vec), .result(result), .mem_req(mem_req),
        .collate_busy(collate_busy), .source_offset(source_offset), .dest_offset(dest_offset));
    scc_mem_model mem (.clk_sys(clk_sys), .rstn(rstn), .mem_req(mem_req),
        .table_base_reg(table_base_reg), .slow(slow), .mem_valid(mem_valid),
        .memory_read_data_reg(memory_read_data_reg), .fetch_count(fetch_count));
    ////////////////////////////////////////////////////////////
    // Helpers: random source, character access, comparison, verdict
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    function automatic logic [5:0] coll(input logic [5:0] c);
        return c & 6'h36;
    endfunction : coll
    function automatic logic [5:0] ch(input logic [59:0] w, input int k);
        return w[59-6*k -: 6];
    endfunction : ch
    function automatic logic [59:0] put(input logic [59:0] w, input int k, input logic [5:0] c);
        logic [59:0] r;
        r = w;
        r[59-6*k -: 6] = c;
        return r;
    endfunction : put
    task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask : chk
    task automatic summarize();
        if (fail_count == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : summarize
    // Strobes last one cycle; data changes only right after an edge
    task automatic strobe(input logic [4:0] v, input logic [DBL_W-1:0] sd, input logic fr);
        @(posedge clk_sys);
        {load_residue, load_form, load_buffer, compare_go, new_instr} <= v;
        shift_data <= sd;
        form_from_residue <= fr;
    endtask : strobe
    task automatic newi();
        strobe(5'b00001, '0, 1'b0);
        strobe(5'b00000, '0, 1'b0);
        frc = 0;
        wp = -1;
    endtask : newi
    ////////////////////////////////////////////////////////////
    // Compare one pair against the model; collate path when enabled
    task automatic cmp(input logic [59:0] a, input logic [59:0] b);
        logic [9:0] eqv;
        logic [5:0] ts, tq;
        int p, nf, f0, n;
        p = -1;
        for (int k = 9; k >= 0; k--) begin
            eqv[k] = (ch(a, k) == ch(b, k)) || (k < frc);
            if (!eqv[k]) p = k;
        end
        ts = ch(a, (p < 0) ? 0 : p);
        tq = ch(b, (p < 0) ? 0 : p);
        nf = int'(ts[5:3] != wp);
        if (ts[5:3] != tq[5:3]) nf = nf + int'(tq[5:3] != wp);
        slow <= ~slow;
        strobe(5'b01000, {12'h000, a, 48'h0}, 1'b0);
        strobe(5'b00100, {12'h000, a, 48'h0}, 1'b0);
        strobe(5'b01000, {12'h000, b, 48'h0}, 1'b0);
        strobe(5'b00010, {12'h000, b, 48'h0}, 1'b0);
        f0 = fetch_count;
        strobe(5'b00000, {12'h000, b, 48'h0}, 1'b0);
        @(posedge clk_sys);
        #1;
        chk("char_equal_vec", char_equal_vec, eqv);
        chk("word_equal", result.word_equal, &eqv);
        chk("mismatch", result.mismatch, ~&eqv);
        if (p >= 0) chk("pos", result.pos, p);
        if (!collate_mode) begin
            repeat (2) @(posedge clk_sys);
            #1;
            if (p >= 0) chk("greater", result.greater, tq > ts);
        end else if (p >= 0) begin
            chk("busy", collate_busy, 1'b1);
            n = 0;
            while (!(result.collate_equal || result.collate_unequal) && n < 60) begin
                @(posedge clk_sys);
                #1;
                n++;
            end
            if (!(result.collate_equal || result.collate_unequal)) begin
                chk("collate_done", 1'b0, 1'b1);
                summarize();
            end
            chk("idle", collate_busy, 1'b0);
            chk("fetches", 8'(fetch_count - f0), nf);
            chk("collate_equal", result.collate_equal, coll(ts) == coll(tq));
            chk("collate_unequal", result.collate_unequal, coll(ts) != coll(tq));
            if (coll(ts) != coll(tq)) chk("cgreater", result.greater, coll(tq) > coll(ts));
            if (coll(ts) == coll(tq)) frc = p + 1;
            if (nf == 2) wp = tq[5:3];
            else if (nf == 1) wp = (ts[5:3] != wp) ? ts[5:3] : tq[5:3];
        end
    endtask : cmp
    ////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        logic [59:0] a, b;
        logic [119:0] sd;
        logic [31:0] r;
        repeat (10) @(posedge clk_sys);
        #1;
        chk("reset_result", result, '0);
        chk("reset_req", mem_req, '0);
        rstn <= 1'b1;
        table_base_reg <= 18'(rnd());
        // Offset registers load both nibbles together
        for (int i = 0; i < 3; i++) begin
            @(posedge clk_sys);
            offset_load <= 1'b1;
            source_offset_in <= 4'(rnd());
            dest_offset_in <= 4'(rnd());
            @(posedge clk_sys);
            offset_load <= 1'b0;
            @(posedge clk_sys);
            #1;
            chk("source_offset", source_offset, source_offset_in);
            chk("dest_offset", dest_offset, dest_offset_in);
        end
        // Word formation by slice and by residue, seen through the move path
        move_op <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            sd = 120'({rnd(), rnd(), rnd(), rnd()});
            strobe(5'b10000, sd, i[0]);
            strobe(5'b01000, sd, i[0]);
            strobe(5'b00100, sd, i[0]);
            strobe(5'b00000, sd, i[0]);
            repeat (3) @(posedge clk_sys);
            #1;
            if (i[0]) begin
                chk("residue_word", out_word[47:0], sd[47:0]);
                chk("residue_top", out_word[59:54], sd[113:108]);
                chk("holding", memory_write_holding_reg[47:0], sd[47:0]);
            end else begin
                chk("slice_word", out_word, sd[107:48]);
                chk("holding", memory_write_holding_reg, sd[107:48]);
            end
        end
        // Uncollated: every mismatch position, later differences ignored
        newi();
        for (int k = 0; k < 11; k++) begin
            a = 60'({rnd(), rnd()});
            r = rnd();
            b = (k == 10) ? a : put(a, k, ch(a, k) ^ (r[5:0] | 6'h01));
            if (k < 9) b = put(b, 9, ~ch(b, 9));
            cmp(a, b);
        end
        // Collated: two instructions covering 2, 0, 1 fetch cases and both endings
        collate_mode <= 1'b1;
        for (int g = 0; g < 2; g++) begin
            newi();
            a = 60'({rnd(), rnd()});
            b = a;
            for (int j = 3 * g; j < 3 * g + 3; j++) begin
                a = put(a, pos_t[j], ts_t[j]);
                b = put(b, pos_t[j], tq_t[j]);
            end
            for (int j = 0; j < 3; j++) cmp(a, b);
        end
        summarize();
    end
endmodule : tb_top
